// File: core/timer_pair.sv
// Pair of cascadable 8-bit interval timers with pulse and PWM output.
// Assumes a byte register port on the system clock and an async count pin.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Clearing run bit halts and zeroes counter
// - Interval is one to 256 tap periods
// - Lower clock: pin, div8, div32, div128
// - Upper clock: lower match, div8, div128, div2048
// - Interval match toggles flip-flop onto pin
// - Mode 01 joins timers into 16 bits
// - 16-bit upper counts on lower overflow
// - Low write suspends 16-bit joint compare, high resumes
// - 16-bit lower match pulses without clearing
// - Double match clears both, raises interrupt
// - Double match toggles only when inversion enabled
// - Pulse mode: lower timer drives pin only
// - Pulse mode toggles on either compare match
// - Pulse mode buffer loads on high match
// - PWM uses lower timer; upper stays independent
// - PWM toggles on compare and period overflow
// - PWM overflow clears the lower counter
// - PWM buffer loads on period overflow
// - Mode 00 gives two independent timers
module timer_pair
	import timer_pair_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_b,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	input  wire logic              i_wr_en,
	input  wire logic              i_rd_en,
	output logic      [DATA_W-1:0] o_rd_data,
	input  wire logic              i_ext_count_input,
	output logic                   o_toggle_output_pin,
	output logic                   o_upper_timer_irq,
	output logic                   o_lower_match_pulse
);

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	logic              lower_run, upper_run;
	pair_mode_t        pair_mode_field;
	logic [1:0]        pwm_period_select, upper_clock_select, lower_clock_select;
	logic [DATA_W-1:0] low_compare_reg, low_compare_buf, high_compare_reg;
	logic              toggle_src_upper, inv_en, dbuf_en, cmp_en;
	logic              output_toggle_ff;
	logic [DATA_W-1:0] lower_up_counter, upper_up_counter;
	logic              ext_meta, ext_sync, ext_sync_d, ext_level, ext_rise;
	logic              prescale_div8, prescale_div32, prescale_div128, prescale_div2048;
	logic              run_wr, mode_wr, low_wr, high_wr, ff_wr;
	logic              lower_clk, upper_clk, lower_tick, upper_tick;
	logic [DATA_W-1:0] lo_next, up_next;
	logic              lower_match, high_hit, lower_ovf, pwm_ovf, period_last;
	logic              upper_match, combined, toggle_evt, irq_evt, lower_clear;

	// Increment helper shared by both counters
	function automatic logic [DATA_W-1:0] bump(input logic [DATA_W-1:0] v);
		bump = v + CNT_STEP;
	endfunction

	timer_prescaler u_prescaler (
		.i_clk_sys          (i_clk_sys),
		.i_rst_b            (i_rst_b),
		.o_prescale_div8    (prescale_div8),
		.o_prescale_div32   (prescale_div32),
		.o_prescale_div128  (prescale_div128),
		.o_prescale_div2048 (prescale_div2048)
	);

	// Register write strobes
	assign run_wr  = i_wr_en && (i_addr == OFS_PAIR_RUN);
	assign mode_wr = i_wr_en && (i_addr == OFS_PAIR_MODE);
	assign low_wr  = i_wr_en && (i_addr == OFS_LOW_CMP);
	assign high_wr = i_wr_en && (i_addr == OFS_HIGH_CMP);
	assign ff_wr   = i_wr_en && (i_addr == OFS_FF_CTRL);

	// Count pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_meta   <= 1'b0;
			ext_sync   <= 1'b0;
			ext_sync_d <= 1'b0;
			ext_level  <= 1'b0;
		end else begin
			ext_meta   <= i_ext_count_input;
			ext_sync   <= ext_meta;
			ext_sync_d <= ext_sync;
			if (ext_sync == ext_sync_d) begin
				ext_level <= ext_sync_d;
			end
		end
	end
	assign ext_rise = (ext_sync == ext_sync_d) && ext_sync_d && !ext_level;

	// Run and mode registers
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lower_run          <= 1'b0;
			upper_run          <= 1'b0;
			pair_mode_field    <= MODE_DUAL8;
			pwm_period_select  <= 2'h0;
			upper_clock_select <= 2'h0;
			lower_clock_select <= 2'h0;
		end else begin
			if (run_wr) begin
				lower_run <= i_wr_data[RUN_LOWER_BIT];
				upper_run <= i_wr_data[RUN_UPPER_BIT];
			end
			if (mode_wr) begin
				pair_mode_field    <= pair_mode_t'(i_wr_data[MODE_PAIR_LSB +: 2]);
				pwm_period_select  <= i_wr_data[MODE_PWM_SEL_LSB +: 2];
				upper_clock_select <= i_wr_data[MODE_UPPER_CLK_LSB +: 2];
				lower_clock_select <= i_wr_data[MODE_LOWER_CLK_LSB +: 2];
			end
		end
	end

	// Lower clock source select
	always_comb begin
		case (lower_clock_select)
			2'h0:    lower_clk = ext_rise;
			2'h1:    lower_clk = prescale_div8;
			2'h2:    lower_clk = prescale_div32;
			default: lower_clk = prescale_div128;
		endcase
	end
	assign lower_tick = lower_run && lower_clk;
	assign lo_next    = bump(lower_up_counter);

	// PWM period end for the selected 2^n length
	always_comb begin
		case (pwm_period_select)
			PWM_SEL_64:  period_last = &lower_up_counter[5:0];
			PWM_SEL_128: period_last = &lower_up_counter[6:0];
			default:     period_last = (lower_up_counter == CNT_LAST);
		endcase
	end

	// Lower comparator events
	assign lower_match = lower_tick && (lo_next == low_compare_reg);
	assign high_hit    = lower_tick && (lo_next == high_compare_reg)
	                     && (pair_mode_field == MODE_PULSE);
	assign lower_ovf   = lower_tick && (lower_up_counter == CNT_LAST);
	assign pwm_ovf     = lower_tick && period_last && (pair_mode_field == MODE_PWM);

	// Upper clock: lower overflow in 16-bit mode, else the selected source
	always_comb begin
		if (pair_mode_field == MODE_CASCADE16) begin
			upper_clk = lower_ovf;
		end else begin
			case (upper_clock_select)
				2'h0:    upper_clk = lower_match;
				2'h1:    upper_clk = prescale_div8;
				2'h2:    upper_clk = prescale_div128;
				default: upper_clk = prescale_div2048;
			endcase
		end
	end
	// Upper counter idles in pulse mode
	assign upper_tick  = upper_run && upper_clk && (pair_mode_field != MODE_PULSE);
	assign up_next     = bump(upper_up_counter);
	assign upper_match = upper_tick && (up_next == high_compare_reg);
	// Joint 16-bit match needs both comparators and an armed compare
	assign combined    = (pair_mode_field == MODE_CASCADE16) && lower_match && cmp_en
	                     && (upper_up_counter == high_compare_reg);

	// Lower clear condition per mode
	always_comb begin
		case (pair_mode_field)
			MODE_DUAL8:     lower_clear = lower_match;
			MODE_CASCADE16: lower_clear = combined;
			MODE_PULSE:     lower_clear = high_hit;
			default:        lower_clear = pwm_ovf;
		endcase
	end

	// Toggle and interrupt events per mode
	always_comb begin
		case (pair_mode_field)
			MODE_DUAL8: begin
				toggle_evt = toggle_src_upper ? upper_match : lower_match;
				irq_evt    = upper_match;
			end
			MODE_CASCADE16: begin
				toggle_evt = combined;
				irq_evt    = combined;
			end
			MODE_PULSE: begin
				toggle_evt = lower_match || high_hit;
				irq_evt    = 1'b0;
			end
			default: begin
				toggle_evt = lower_match || pwm_ovf;
				irq_evt    = upper_match;
			end
		endcase
	end

	// Lower up counter
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lower_up_counter <= RST_BYTE;
		end else if ((run_wr && !i_wr_data[RUN_LOWER_BIT]) || !lower_run) begin
			lower_up_counter <= RST_BYTE;
		end else if (lower_clear) begin
			lower_up_counter <= RST_BYTE;
		end else if (lower_tick) begin
			lower_up_counter <= lo_next;
		end
	end

	// Upper up counter
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			upper_up_counter <= RST_BYTE;
		end else if ((run_wr && !i_wr_data[RUN_UPPER_BIT]) || !upper_run) begin
			upper_up_counter <= RST_BYTE;
		end else if (combined) begin
			upper_up_counter <= RST_BYTE;
		end else if (pair_mode_field != MODE_CASCADE16 && upper_match) begin
			upper_up_counter <= RST_BYTE;
		end else if (upper_tick) begin
			upper_up_counter <= up_next;
		end
	end

	// Compare registers; low may be double buffered in pulse and PWM modes
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_compare_reg  <= RST_BYTE;
			low_compare_buf  <= RST_BYTE;
			high_compare_reg <= RST_BYTE;
		end else begin
			if (low_wr) begin
				low_compare_buf <= i_wr_data;
				if (!dbuf_en || pair_mode_field == MODE_DUAL8
				    || pair_mode_field == MODE_CASCADE16) begin
					low_compare_reg <= i_wr_data;
				end
			end else if (dbuf_en && high_hit) begin
				low_compare_reg <= low_compare_buf;
			end else if (dbuf_en && pwm_ovf) begin
				low_compare_reg <= low_compare_buf;
			end
			if (high_wr) begin
				high_compare_reg <= i_wr_data;
			end
		end
	end

	// Compare arm: low write suspends, high write re-arms
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cmp_en <= 1'b1;
		end else if (high_wr) begin
			cmp_en <= 1'b1;
		end else if (low_wr) begin
			cmp_en <= 1'b0;
		end
	end

	// Flip-flop control and the toggle flip-flop; software command wins
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			toggle_src_upper <= 1'b0;
			inv_en           <= 1'b0;
			dbuf_en          <= 1'b0;
			output_toggle_ff <= 1'b0;
		end else if (ff_wr) begin
			toggle_src_upper <= i_wr_data[FF_SRC_UPPER_BIT];
			inv_en           <= i_wr_data[FF_INV_EN_BIT];
			dbuf_en          <= i_wr_data[FF_DBUF_EN_BIT];
			case (i_wr_data[FF_CMD_LSB +: 2])
				FF_CMD_INVERT: output_toggle_ff <= !output_toggle_ff;
				FF_CMD_SET:    output_toggle_ff <= 1'b1;
				FF_CMD_CLEAR:  output_toggle_ff <= 1'b0;
				default:       output_toggle_ff <= output_toggle_ff;
			endcase
		end else if (toggle_evt && inv_en) begin
			output_toggle_ff <= !output_toggle_ff;
		end
	end
	assign o_toggle_output_pin = output_toggle_ff;

	// Registered event pulses
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_upper_timer_irq   <= 1'b0;
			o_lower_match_pulse <= 1'b0;
		end else begin
			o_upper_timer_irq   <= irq_evt;
			o_lower_match_pulse <= lower_match;
		end
	end

	// Read port; compare registers read as zero
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= RST_BYTE;
		end else if (!i_rd_en) begin
			o_rd_data <= RST_BYTE;
		end else if (i_addr == OFS_PAIR_RUN) begin
			o_rd_data <= {6'h00, upper_run, lower_run};
		end else if (i_addr == OFS_PAIR_MODE) begin
			o_rd_data <= {pair_mode_field, pwm_period_select,
			              upper_clock_select, lower_clock_select};
		end else if (i_addr == OFS_FF_CTRL) begin
			o_rd_data <= {2'h0, output_toggle_ff, dbuf_en, FF_CMD_KEEP,
			              inv_en, toggle_src_upper};
		end else if (i_addr == OFS_LOWER_CNT) begin
			o_rd_data <= lower_up_counter;
		end else if (i_addr == OFS_UPPER_CNT) begin
			o_rd_data <= upper_up_counter;
		end else begin
			o_rd_data <= RST_BYTE;
		end
	end

	a_run_stop_clear: assert property (
		run_wr && !i_wr_data[RUN_LOWER_BIT] |=> lower_up_counter == RST_BYTE && !lower_run)
		else $error("lower counter not cleared on stop");

	a_interval_restart: assert property (
		pair_mode_field == MODE_DUAL8 && lower_match && !run_wr
		|=> lower_up_counter == RST_BYTE ##1 o_lower_match_pulse == 1'b0 || lower_match)
		else $error("interval match did not restart lower counter");

	a_cascade_no_clear: assert property (
		pair_mode_field == MODE_CASCADE16 && lower_match && !combined && !run_wr
		|=> lower_up_counter == $past(lo_next) && o_lower_match_pulse)
		else $error("lower counter cleared by its own match in 16-bit mode");

	a_cascade_upper_clk: assert property (
		pair_mode_field == MODE_CASCADE16 && upper_run && lower_ovf && !combined && !run_wr
		|=> upper_up_counter == bump($past(upper_up_counter)))
		else $error("upper counter missed lower overflow");

	a_joint_match_irq: assert property (
		combined |=> o_upper_timer_irq && lower_up_counter == RST_BYTE
		&& upper_up_counter == RST_BYTE)
		else $error("joint match did not clear and interrupt");

	a_joint_toggle: assert property (
		combined && !ff_wr |=> output_toggle_ff == ($past(output_toggle_ff) ^ $past(inv_en)))
		else $error("joint match toggle wrong");

	a_compare_suspend: assert property (
		low_wr ##1 !high_wr [*2] |-> !combined)
		else $error("compare active after low write");

	a_pulse_period: assert property (
		high_hit && !run_wr |=> lower_up_counter == RST_BYTE)
		else $error("pulse period did not restart");

	a_pwm_overflow: assert property (
		pwm_ovf && !run_wr |=> lower_up_counter == RST_BYTE)
		else $error("pwm overflow did not clear counter");

	a_buffer_transfer: assert property (
		dbuf_en && (high_hit || pwm_ovf) && !low_wr && !ff_wr
		|=> low_compare_reg == $past(low_compare_buf))
		else $error("double buffer not transferred");

endmodule
`default_nettype wire

// File: core/timer_prescaler.sv
// Free-running prescaler producing one-cycle tap enables.
// Assumes one system clock; taps are enables, never clocks.
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler
	import timer_pair_pkg::*;
#(
	parameter int WIDTH = TAP_DIV2048_BITS
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	output logic      o_prescale_div8,
	output logic      o_prescale_div32,
	output logic      o_prescale_div128,
	output logic      o_prescale_div2048
);

	logic [WIDTH-1:0] count;

	// Refuse a divider too short for the slowest tap, at elaboration
	if (WIDTH < TAP_DIV2048_BITS) begin : g_width_check
		$error("prescaler width too small");
	end

	// Free-running divider
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// Tap enables fire on the last count of each period
	assign o_prescale_div8    = &count[TAP_DIV8_BITS-1:0];
	assign o_prescale_div32   = &count[TAP_DIV32_BITS-1:0];
	assign o_prescale_div128  = &count[TAP_DIV128_BITS-1:0];
	assign o_prescale_div2048 = &count[TAP_DIV2048_BITS-1:0];

endmodule
`default_nettype wire

// File: pkg/timer_pair_pkg.sv
// Constants, field layout and mode encoding for the cascadable timer pair.
// Assumes a 10 MHz system clock and a byte-wide register port.
package timer_pair_pkg;

	// System clock
	localparam int SYS_CLK_HZ     = 10_000_000;
	localparam int SYS_PERIOD_NS  = 1_000_000_000 / SYS_CLK_HZ;

	// Register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_PAIR_RUN   = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PAIR_MODE  = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_LOW_CMP    = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_HIGH_CMP   = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_FF_CTRL    = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_LOWER_CNT  = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_UPPER_CNT  = 3'h6;

	// Run register bits
	localparam int RUN_LOWER_BIT = 0;
	localparam int RUN_UPPER_BIT = 1;

	// Mode register fields
	localparam int MODE_LOWER_CLK_LSB = 0;
	localparam int MODE_UPPER_CLK_LSB = 2;
	localparam int MODE_PWM_SEL_LSB   = 4;
	localparam int MODE_PAIR_LSB      = 6;

	// Toggle flip-flop control fields
	localparam int FF_SRC_UPPER_BIT = 0;
	localparam int FF_INV_EN_BIT    = 1;
	localparam int FF_CMD_LSB       = 2;
	localparam int FF_DBUF_EN_BIT   = 4;
	localparam int FF_STATE_BIT     = 5;
	localparam logic [1:0] FF_CMD_INVERT = 2'h0;
	localparam logic [1:0] FF_CMD_SET    = 2'h1;
	localparam logic [1:0] FF_CMD_CLEAR  = 2'h2;
	localparam logic [1:0] FF_CMD_KEEP   = 2'h3;

	// Reset value, last count and count step
	localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
	localparam logic [DATA_W-1:0] CNT_LAST   = 8'hFF;
	localparam logic [DATA_W-1:0] CNT_STEP   = 8'h01;

	// Prescaler tap widths: a tap fires once per 2^bits system clocks
	localparam int TAP_DIV8_BITS    = 3;
	localparam int TAP_DIV32_BITS   = 5;
	localparam int TAP_DIV128_BITS  = 7;
	localparam int TAP_DIV2048_BITS = 11;

	// Pair operating modes, in field order
	typedef enum logic [1:0] {
		MODE_DUAL8,
		MODE_CASCADE16,
		MODE_PULSE,
		MODE_PWM
	} pair_mode_t;

	// PWM period selections
	localparam logic [1:0] PWM_SEL_64  = 2'h1;
	localparam logic [1:0] PWM_SEL_128 = 2'h2;

endpackage

// File: tb/pin_partner.sv
// Model of the circuit on the pin side: watches the toggle pin, drives the count pin.
// Assumes the system clock; the count pin rests low while no burst is asked for.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic       i_pin,
	input  wire logic       i_gen_en,
	input  wire logic [7:0] i_half,
	output logic            o_count,
	output logic            o_pin_event
);
	logic       last_pin;
	logic [7:0] hcnt;

	// Flags every change seen on the toggle pin
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			last_pin    <= 1'b0;
			o_pin_event <= 1'b0;
		end else begin
			last_pin    <= i_pin;
			o_pin_event <= i_pin ^ last_pin;
		end
	end

	// Square wave on the count pin, half period in clocks
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_count <= 1'b0;
			hcnt    <= 8'h00;
		end else if (!i_gen_en) begin
			o_count <= 1'b0;
			hcnt    <= 8'h00;
		end else if (hcnt == i_half - 8'h01) begin
			o_count <= ~o_count;
			hcnt    <= 8'h00;
		end else begin
			hcnt <= hcnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: tb/timer_pair_bench.sv
// Self-checking bench for the timer pair: register tasks and period checks per mode.
// Assumes the pin partner model and a 10 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module timer_pair_bench
	import timer_pair_pkg::*;
;
	logic              clk;
	logic              rst_b;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_en;
	logic              rd_en;
	logic [DATA_W-1:0] rd_data;
	logic              ext_in;
	logic              pin;
	logic              irq;
	logic              lpulse;
	logic              gen_en;
	logic [7:0]        half;
	logic              pin_ev;
	int                err_count;
	int                n_compared;

	timer_pair u_timer_pair (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr),
		.i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
		.i_ext_count_input(ext_in), .o_toggle_output_pin(pin),
		.o_upper_timer_irq(irq), .o_lower_match_pulse(lpulse));
	pin_partner u_pin_partner (.i_clk_sys(clk), .i_rst_b(rst_b), .i_pin(pin),
		.i_gen_en(gen_en), .i_half(half), .o_count(ext_in), .o_pin_event(pin_ev));

	// System clock
	initial clk = 1'b0;
	always #(SYS_PERIOD_NS / 2) clk = ~clk;

	function automatic logic ev(int s);
		if (s == 0) return lpulse === 1'b1;
		if (s == 1) return irq === 1'b1;
		return pin_ev === 1'b1;
	endfunction
	function automatic logic [7:0] modeb(int p, int w, int u, int l);
		return 8'((p << MODE_PAIR_LSB) | (w << MODE_PWM_SEL_LSB) |
			(u << MODE_UPPER_CLK_LSB) | (l << MODE_LOWER_CLK_LSB));
	endfunction
	function automatic logic [7:0] ffb(int src, int inv, logic [1:0] cmd, int dbuf);
		return 8'((dbuf << FF_DBUF_EN_BIT) | (int'(cmd) << FF_CMD_LSB) |
			(inv << FF_INV_EN_BIT) | (src << FF_SRC_UPPER_BIT));
	endfunction

	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic fail_wait(string nm);
		err_count++;
		$display("[ERR] %s expected event seen none", nm);
		tally_and_finish();
	endtask
	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// Cycles between two successive events of one source
	task automatic gap(int s, int lim, output int c);
		int n;
		for (n = 0; n < lim && !ev(s); n++) step();
		if (n == lim) fail_wait("first event");
		c = 0;
		do begin
			step();
			c++;
		end while (!ev(s) && c < lim);
		if (c == lim) fail_wait("next event");
	endtask
	task automatic quiet(int s, int n, string nm);
		int k;
		k = 0;
		repeat (n) begin
			step();
			if (ev(s)) k++;
		end
		chk(nm, k, 0);
	endtask
	// Events of one source within one interrupt period, bounded in cycles
	task automatic between(int s, output int k);
		int g, t;
		gap(1, 6000, g);
		k = 0;
		t = 0;
		do begin
			step();
			t++;
			if (ev(s)) k++;
		end while (!ev(1) && t < 6000);
		if (!ev(1)) fail_wait("period end");
	endtask
	task automatic cfg(logic [7:0] m, logic [7:0] f, logic [7:0] lo, logic [7:0] hi,
		logic [7:0] run);
		wr(OFS_PAIR_RUN, 8'h00);
		wr(OFS_PAIR_MODE, m);
		wr(OFS_FF_CTRL, f);
		wr(OFS_LOW_CMP, lo);
		wr(OFS_HIGH_CMP, hi);
		wr(OFS_PAIR_RUN, run);
	endtask
	// Two pin gaps of a pulse or pwm period
	task automatic pair(int per, int lo);
		int g1, g2;
		gap(2, 5000, g1);
		gap(2, 5000, g2);
		chk("pulse period", g1 + g2, 8 * per);
		chk("pulse low part", (g1 < g2) ? g1 : g2, 8 * lo);
	endtask

	// Main sequence
	initial begin
		int g, k;
		logic [7:0] d, lo, hi;
		int dv[3] = '{8, 32, 128};
		int uv[4] = '{48, 16, 256, 4096};
		int pv[3] = '{64, 128, 256};
		rst_b = 1'b0;
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		gen_en = 1'b0;
		half = 8'h05;
		err_count = 0;
		n_compared = 0;
		void'($urandom(32'hab13));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		step();
		chk("pin after reset", pin, 0);
		wr(OFS_LOW_CMP, 8'h55);
		rd(OFS_LOW_CMP, d);
		chk("low compare read", d, 0);
		rd(3'h7, d);
		chk("unmapped read", d, 0);
		rd(OFS_FF_CTRL, d);
		chk("ff control read", d, 8'h0C);
		wr(OFS_FF_CTRL, ffb(0, 0, FF_CMD_SET, 0));
		rd(OFS_FF_CTRL, d);
		chk("ff set read", d, 8'h2C);
		chk("pin after set", pin, 1);
		wr(OFS_FF_CTRL, ffb(0, 0, FF_CMD_INVERT, 0));
		rd(OFS_FF_CTRL, d);
		chk("ff invert read", d, 8'h0C);
		chk("pin after invert", pin, 0);
		rd(OFS_LOWER_CNT, d);
		chk("lower count at reset", d, 0);
		step();
		chk("read data after", rd_data, 0);
		// Lower timer on each prescaler tap
		for (int i = 0; i < 3; i++) begin
			lo = 8'($urandom_range(20, 2));
			cfg(modeb(0, 0, 0, i + 1), ffb(0, 1, FF_CMD_CLEAR, 0), lo, 8'h00, 8'h01);
			gap(0, 4000, g);
			chk("lower interval", g, dv[i] * lo);
			gap(2, 4000, g);
			chk("lower pin interval", g, dv[i] * lo);
		end
		gen_en <= 1'b1;
		cfg(modeb(0, 0, 0, 0), ffb(0, 1, FF_CMD_CLEAR, 0), 8'h04, 8'h00, 8'h01);
		gap(0, 2000, g);
		chk("pin count interval", g, 40);
		gen_en <= 1'b0;
		// Upper timer on each of its sources
		for (int i = 0; i < 4; i++) begin
			cfg(modeb(0, 0, i, 1), ffb(1, 1, FF_CMD_CLEAR, 0), 8'h03, 8'h02, 8'h03);
			gap(1, 10000, g);
			chk("upper interval", g, uv[i]);
			gap(2, 10000, g);
			chk("upper pin interval", g, uv[i]);
		end
		wr(OFS_PAIR_RUN, 8'h00);
		rd(OFS_LOWER_CNT, d);
		chk("lower count stopped", d, 0);
		rd(OFS_UPPER_CNT, d);
		chk("upper count stopped", d, 0);
		repeat (50) step();
		rd(OFS_LOWER_CNT, d);
		chk("lower count held", d, 0);
		// Cascaded 16-bit interval, upper clock field ignored
		cfg(modeb(1, 0, 3, 1), ffb(0, 1, FF_CMD_CLEAR, 0), 8'h04, 8'h02, 8'h03);
		rd(OFS_PAIR_MODE, d);
		chk("mode read", d, modeb(1, 0, 3, 1));
		gap(1, 6000, g);
		chk("cascade interval", g, 4128);
		between(0, k);
		chk("lower pulses per period", k, 3);
		gap(2, 6000, g);
		chk("cascade pin interval", g, 4128);
		wr(OFS_FF_CTRL, ffb(0, 0, FF_CMD_KEEP, 0));
		quiet(2, 9000, "pin without inversion");
		// Restart from zero so a joint match falls inside the quiet window
		wr(OFS_PAIR_RUN, 8'h00);
		wr(OFS_LOW_CMP, 8'h04);
		wr(OFS_PAIR_RUN, 8'h03);
		quiet(1, 4400, "irq after low write");
		// Disarmed counters run past the match, so restart after re-arming
		wr(OFS_PAIR_RUN, 8'h00);
		wr(OFS_HIGH_CMP, 8'h02);
		wr(OFS_PAIR_RUN, 8'h03);
		gap(1, 10000, g);
		chk("cascade rearmed", g, 4128);
		// Pulse generation, then with the low buffer
		lo = 8'($urandom_range(8, 2));
		hi = 8'($urandom_range(40, 20));
		cfg(modeb(2, 0, 0, 1), ffb(0, 1, FF_CMD_CLEAR, 0), lo, hi, 8'h03);
		pair(hi, lo);
		quiet(1, 700, "irq in pulse mode");
		wr(OFS_FF_CTRL, ffb(0, 1, FF_CMD_KEEP, 1));
		wr(OFS_LOW_CMP, lo + 8'h01);
		repeat (3) gap(2, 1000, g);
		pair(hi, lo + 1);
		// Pwm on every period, upper timer alongside
		for (int i = 0; i < 3; i++) begin
			lo = 8'($urandom_range(pv[i] / 2 - 2, 1));
			cfg(modeb(3, i + 1, 1, 1), ffb(0, 1, FF_CMD_CLEAR, 0), lo, 8'h05, 8'h03);
			pair(pv[i], lo);
			gap(1, 1000, g);
			chk("upper in pwm", g, 40);
		end
		wr(OFS_FF_CTRL, ffb(0, 1, FF_CMD_KEEP, 1));
		wr(OFS_LOW_CMP, lo + 8'h01);
		repeat (3) gap(2, 5000, g);
		pair(256, lo + 1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
